// file: pmc_pkg.sv
// pmc_pkg: constants for the privileged mode control block.
// assumes one core clock and a software-driven register port.
package pmc_pkg;
    // register offsets (byte addresses, word aligned)
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_BASE     = 8'h08;
    localparam logic [7:0] OFF_RET_ADDR = 8'h0C;
    localparam logic [7:0] OFF_EVENT    = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_CLR  = 8'h18;
    localparam logic [7:0] OFF_IRQ_EN   = 8'h1C;
    localparam logic [7:0] OFF_PC       = 8'h20;
    localparam logic [7:0] OFF_SCRATCH  = 8'h40;
    // control bit positions
    localparam int CTRL_SHADOW_BIT = 0;
    // event codes written to OFF_EVENT
    localparam logic [3:0] EV_IFILL   = 4'h1;
    localparam logic [3:0] EV_DFILL   = 4'h2;
    localparam logic [3:0] EV_INTR    = 4'h3;
    localparam logic [3:0] EV_MACHINE_CHECK_ERROR    = 4'h4;
    localparam logic [3:0] EV_ARITHMETIC_EXCEPTION   = 4'h5;
    localparam logic [3:0] EV_DFETCH  = 4'h6;
    localparam logic [3:0] EV_CALL    = 4'h7;
    localparam logic [3:0] EV_MODEOP  = 4'h8;
    localparam logic [3:0] EV_RETURN  = 4'h9;
    // mode-only opcode selectors (event word bits 6:4)
    localparam logic [2:0] OP_MFIR = 3'h0;
    localparam logic [2:0] OP_MTIR = 3'h1;
    localparam logic [2:0] OP_ULD  = 3'h2;
    localparam logic [2:0] OP_UST  = 3'h3;
    localparam logic [2:0] OP_RET  = 3'h4;
    localparam int MODE_OPS = 5;
    // entry offsets from the firmware base
    localparam logic [31:0] ENT_RESET  = 32'h0000_0000;
    localparam logic [31:0] ENT_INTR   = 32'h0000_0100;
    localparam logic [31:0] ENT_IFILL  = 32'h0000_0180;
    localparam logic [31:0] ENT_DFILL  = 32'h0000_0200;
    localparam logic [31:0] ENT_DFETCH = 32'h0000_0380;
    localparam logic [31:0] ENT_MACHINE_CHECK_ERROR   = 32'h0000_0400;
    localparam logic [31:0] ENT_ILLOP  = 32'h0000_0480;
    localparam logic [31:0] ENT_ARITHMETIC_EXCEPTION  = 32'h0000_0500;
    localparam logic [31:0] ENT_CALL   = 32'h0000_2000;
    // reset values
    localparam logic [31:0] RST_BASE = 32'h0000_0000;
    localparam logic [31:0] RST_PC   = 32'h0000_0001;
    // drain time before dispatch, in cycles
    localparam int DRAIN_CYCLES = 4;
    // irq status bits
    localparam int IRQ_ENTRY  = 0;
    localparam int IRQ_RETURN = 1;
    localparam int IRQ_ILLOP  = 2;
    typedef enum logic [1:0] {
        PMC_RUN   = 2'b00,
        PMC_DRAIN = 2'b01,
        PMC_SAVE  = 2'b10
    } pmc_state_t;
endpackage : pmc_pkg

// file: pmc_top.sv
// pmc_top: privileged firmware mode control, with its register port.
// assumes a single-cycle strobed register master on SYS_CLK; events other
// than interrupts on INTR_REQ are posted by software through the event register.
`timescale 1ns/100ps
`default_nettype none
module pmc_top #(
    parameter int SCRATCH_WORDS = 24
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RESETN,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    input  wire logic        INTR_REQ,
    output logic [31:0]      RDATA,
    output logic [31:0]      FETCH_PC,
    output logic             FW_MODE,
    output logic             IMAP_EN,
    output logic             DMAP_EN,
    output logic             INTR_EN,
    output logic             SHADOW_SEL,
    output logic             IRQ
);
    pmc_pkg::pmc_state_t state;
    pmc_pkg::pmc_state_t next_state;
    logic [31:0] pc;
    logic [31:0] ret_addr;
    logic [31:0] base;
    logic [31:0] entry_off;
    logic [31:0] next_ret;
    logic        shadow_en;
    logic [2:0]  drain_cnt;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_en;
    logic [31:0] scratch [SCRATCH_WORDS];
    logic [31:0] mir_data;

    // register decode
    wire sel_ev   = WR && ADDR == pmc_pkg::OFF_EVENT;
    wire [3:0] ev_code = WDATA[3:0];
    wire [2:0] ev_op   = WDATA[6:4];
    wire [4:0] scr_idx = WDATA[12:8];
    wire idle     = state == pmc_pkg::PMC_RUN;
    wire fw       = pc[0];
    // only opcode selectors below the count are real mode-only opcodes
    wire op_valid = 32'(ev_op) < pmc_pkg::MODE_OPS;
    wire is_mode_op = sel_ev && ev_code == pmc_pkg::EV_MODEOP && op_valid;
    wire illegal  = is_mode_op && !fw;
    wire intr_take = idle && INTR_REQ && !fw;
    wire ev_entry = sel_ev && idle && (ev_code inside {
        pmc_pkg::EV_IFILL, pmc_pkg::EV_DFILL, pmc_pkg::EV_MACHINE_CHECK_ERROR,
        pmc_pkg::EV_ARITHMETIC_EXCEPTION, pmc_pkg::EV_DFETCH, pmc_pkg::EV_CALL});
    wire start    = intr_take || (idle && illegal) || (!intr_take && ev_entry);
    wire do_ret   = idle && is_mode_op && fw && ev_op == pmc_pkg::OP_RET;
    wire do_mtir  = idle && is_mode_op && fw && ev_op == pmc_pkg::OP_MTIR;
    wire do_mfir  = idle && is_mode_op && fw && ev_op == pmc_pkg::OP_MFIR;
    wire scr_ok   = 32'(scr_idx) < SCRATCH_WORDS;
    wire ctrl_wr  = WR && ADDR == pmc_pkg::OFF_CTRL;
    wire base_wr  = WR && ADDR == pmc_pkg::OFF_BASE;
    wire ret_wr   = WR && ADDR == pmc_pkg::OFF_RET_ADDR;
    wire clr_wr   = WR && ADDR == pmc_pkg::OFF_IRQ_CLR;
    wire en_wr    = WR && ADDR == pmc_pkg::OFF_IRQ_EN;

    // entry selection by event type; interrupt wins over posted events
    function automatic logic [31:0] entry_of(input logic [3:0] code);
        case (code)
            pmc_pkg::EV_IFILL:  entry_of = pmc_pkg::ENT_IFILL;
            pmc_pkg::EV_DFILL:  entry_of = pmc_pkg::ENT_DFILL;
            pmc_pkg::EV_MACHINE_CHECK_ERROR:   entry_of = pmc_pkg::ENT_MACHINE_CHECK_ERROR;
            pmc_pkg::EV_ARITHMETIC_EXCEPTION:  entry_of = pmc_pkg::ENT_ARITHMETIC_EXCEPTION;
            pmc_pkg::EV_DFETCH: entry_of = pmc_pkg::ENT_DFETCH;
            pmc_pkg::EV_CALL:   entry_of = pmc_pkg::ENT_CALL;
            default:            entry_of = pmc_pkg::ENT_ILLOP;
        endcase
    endfunction : entry_of

    wire [31:0] sel_off = intr_take ? pmc_pkg::ENT_INTR
                        : illegal   ? pmc_pkg::ENT_ILLOP
                        : entry_of(ev_code);

    // state sequencing: drain, then save and dispatch
    always_comb begin
        next_state = state;
        case (state)
            pmc_pkg::PMC_RUN:   if (start) next_state = pmc_pkg::PMC_DRAIN;
            pmc_pkg::PMC_DRAIN: begin
                if (32'(drain_cnt) == pmc_pkg::DRAIN_CYCLES - 1)
                    next_state = pmc_pkg::PMC_SAVE;
            end
            pmc_pkg::PMC_SAVE:  next_state = pmc_pkg::PMC_RUN;
            default:            next_state = pmc_pkg::PMC_RUN;
        endcase
    end

    // saved return address: software may rewrite it, entry overrides
    always_comb begin
        next_ret = ret_addr;
        if (ret_wr)
            next_ret = WDATA;
        if (state == pmc_pkg::PMC_SAVE)
            next_ret = pc;
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state     <= pmc_pkg::PMC_RUN;
            drain_cnt <= 3'h0;
            entry_off <= 32'h0000_0000;
        end else begin
            state <= next_state;
            drain_cnt <= (state == pmc_pkg::PMC_DRAIN) ? drain_cnt + 3'h1
                                                       : 3'h0;
            if (start)
                entry_off <= sel_off;
        end
    end

    // program counter and mode flag in its lowest bit
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pc       <= pmc_pkg::RST_PC;
            ret_addr <= 32'h0000_0000;
        end else begin
            ret_addr <= next_ret;
            if (state == pmc_pkg::PMC_SAVE)
                pc <= (base + entry_off) | 32'h0000_0001;
            else if (do_ret)
                pc <= ret_addr;
            else if (WR && ADDR == pmc_pkg::OFF_PC && idle)
                pc <= {WDATA[31:2], 1'b0, pc[0]};              // advance, keep mode
        end
    end

    // base, shadow enable and scratch bank
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            base      <= pmc_pkg::RST_BASE;
            shadow_en <= 1'b0;
        end else begin
            if (base_wr)
                base <= WDATA;
            if (ctrl_wr)
                shadow_en <= WDATA[pmc_pkg::CTRL_SHADOW_BIT];
        end
    end

    // scratch writes only through the move-to opcode
    always_ff @(posedge SYS_CLK) begin
        if (do_mtir && scr_ok)
            scratch[scr_idx] <= {16'h0000, WDATA[31:16]};
    end

    // move-from latches the scratch word for software to read
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN)
            mir_data <= 32'h0000_0000;
        else if (do_mfir)
            mir_data <= scr_ok ? scratch[scr_idx] : 32'h0000_0000;
    end

    // sticky status: set wins over a clear in the same cycle
    wire [2:0] irq_set = {illegal, do_ret,
                          state == pmc_pkg::PMC_SAVE};
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_stat <= 3'h0;
            irq_en   <= 3'h0;
        end else begin
            irq_stat <= (irq_stat & ~(clr_wr ? WDATA[2:0] : 3'h0)) | irq_set;
            if (en_wr)
                irq_en <= WDATA[2:0];
        end
    end

    // read mux; unmapped addresses read zero
    wire [31:0] rd_mux =
        ADDR == pmc_pkg::OFF_CTRL     ? {31'h0, shadow_en} :
        ADDR == pmc_pkg::OFF_STATUS   ? {29'h0, state, pc[0]} :
        ADDR == pmc_pkg::OFF_BASE     ? base :
        ADDR == pmc_pkg::OFF_RET_ADDR ? ret_addr :
        ADDR == pmc_pkg::OFF_IRQ_STAT ? {29'h0, irq_stat} :
        ADDR == pmc_pkg::OFF_IRQ_EN   ? {29'h0, irq_en} :
        ADDR == pmc_pkg::OFF_PC       ? pc :
        ADDR == pmc_pkg::OFF_SCRATCH  ? mir_data : 32'h0000_0000;

    // next values of the mode-derived outputs
    wire [31:0] next_pc = (state == pmc_pkg::PMC_SAVE)
                          ? ((base + entry_off) | 32'h0000_0001)
                          : do_ret ? ret_addr
                          : (WR && ADDR == pmc_pkg::OFF_PC && idle)
                            ? {WDATA[31:2], 1'b0, pc[0]} : pc;
    wire next_fw = next_pc[0];

    // registered outputs; all but RDATA, DMAP_EN and IRQ derive from next_pc so they track pc exactly
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            RDATA      <= 32'h0000_0000;
            FETCH_PC   <= 32'h0000_0000;
            FW_MODE    <= 1'b1;
            IMAP_EN    <= 1'b0;
            DMAP_EN    <= 1'b1;
            INTR_EN    <= 1'b0;
            SHADOW_SEL <= 1'b0;
            IRQ        <= 1'b0;
        end else begin
            RDATA      <= RD ? rd_mux : 32'h0000_0000;
            FETCH_PC   <= {next_pc[31:2], 2'b00};
            FW_MODE    <= next_fw;
            IMAP_EN    <= !next_fw;
            DMAP_EN    <= 1'b1;
            INTR_EN    <= !next_fw;
            SHADOW_SEL <= next_fw && (ctrl_wr
                          ? WDATA[pmc_pkg::CTRL_SHADOW_BIT]
                          : shadow_en);
            IRQ        <= |((irq_stat | irq_set) & irq_en);
        end
    end
endmodule : pmc_top
`default_nettype wire

// file: pmc_checker.sv
// pmc_checker: port-level assertions for the privileged mode control block.
// assumes it is bound to pmc_top; one clock, reset active low.
`timescale 1ns/100ps
`default_nettype none
module pmc_checker (
    input wire logic        SYS_CLK,
    input wire logic        RESETN,
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic [31:0] FETCH_PC,
    input wire logic        FW_MODE,
    input wire logic        IMAP_EN,
    input wire logic        DMAP_EN,
    input wire logic        INTR_EN,
    input wire logic        SHADOW_SEL,
    input wire logic        IRQ
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    // a return request is the only way out of firmware mode
    wire ret_wr = WR && ADDR == pmc_pkg::OFF_EVENT &&
                  WDATA[3:0] == pmc_pkg::EV_MODEOP &&
                  WDATA[6:4] == pmc_pkg::OP_RET;
    a_imap_off:
        assert property (FW_MODE |-> !IMAP_EN && DMAP_EN)
        else $error("instruction mapping on in firmware mode");
    a_intr_masked:
        assert property (FW_MODE |-> !INTR_EN)
        else $error("interrupts enabled in firmware mode");
    a_native_enables:
        assert property (!FW_MODE |-> INTR_EN && IMAP_EN)
        else $error("native mode without interrupts or mapping");
    a_fetch_aligned:
        assert property (FETCH_PC[1:0] == 2'b00)
        else $error("fetch address not longword aligned");
    a_shadow_fw:
        assert property (SHADOW_SEL |-> FW_MODE || $past(FW_MODE))
        else $error("shadow registers selected outside firmware mode");
    a_reset_entry:
        assert property (!$past(RESETN) |-> FW_MODE && FETCH_PC == 32'h0)
        else $error("reset did not start at the reset entry");
    a_leave_by_ret:
        assert property ($fell(FW_MODE) |-> $past(ret_wr))
        else $error("firmware mode left without a return");
    a_drain_first:
        assert property ($rose(FW_MODE) |-> !$past(FW_MODE, 5))
        else $error("entry dispatched without draining");
    // main scenarios reached
    c_entry: cover property ($rose(FW_MODE));
    c_return: cover property ($fell(FW_MODE));
    c_irq: cover property ($rose(IRQ));
endmodule : pmc_checker
`default_nettype wire

// file: pmc_top_tb.sv
// pmc_top_tb: self-checking bench for the privileged mode control block.
// assumes pmc_pkg and pmc_checker are compiled first; 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module pmc_top_tb;
    logic        sys_clk  = 1'b0;
    logic        resetn   = 1'b0;
    logic [7:0]  addr     = 8'h00;
    logic [31:0] wdata    = 32'h0;
    logic        wr       = 1'b0;
    logic        rd       = 1'b0;
    logic        intr_req = 1'b0;
    logic        rd_d     = 1'b0;
    logic [31:0] rdata, fetch_pc, base, x, rnd, evw;
    logic        fw_mode, imap_en, dmap_en, intr_en, shadow_sel, irq;
    logic [31:0] exp_q [$];
    int          mismatches = 0;
    int          n_tests    = 0;
    int          cycles     = 0;
    localparam logic [3:0] EVS [6] = '{pmc_pkg::EV_IFILL, pmc_pkg::EV_DFILL,
        pmc_pkg::EV_MACHINE_CHECK_ERROR, pmc_pkg::EV_ARITHMETIC_EXCEPTION, pmc_pkg::EV_DFETCH,
        pmc_pkg::EV_CALL};
    localparam logic [31:0] OFFS [6] = '{pmc_pkg::ENT_IFILL,
        pmc_pkg::ENT_DFILL, pmc_pkg::ENT_MACHINE_CHECK_ERROR, pmc_pkg::ENT_ARITHMETIC_EXCEPTION,
        pmc_pkg::ENT_DFETCH, pmc_pkg::ENT_CALL};

    pmc_top u_dut (
        .SYS_CLK(sys_clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .INTR_REQ(intr_req), .RDATA(rdata),
        .FETCH_PC(fetch_pc), .FW_MODE(fw_mode), .IMAP_EN(imap_en),
        .DMAP_EN(dmap_en), .INTR_EN(intr_en), .SHADOW_SEL(shadow_sel),
        .IRQ(irq)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // mode flags packed so one compare covers them all
    function automatic logic [31:0] flg();
        return {27'h0, fw_mode, imap_en, dmap_en, intr_en, shadow_sel};
    endfunction : flg
    task automatic end_of_test();
        if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic cmp(input logic [31:0] a, input logic [31:0] e);
        n_tests++;
        if (a !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, a, e);
        end
    endtask : cmp
    // one-cycle strobe; returns at the edge that takes it, so a gap follows
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        @(posedge sys_clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rdx
    // return to native code at na (bits 1:0 clear)
    task automatic to_native(input logic [31:0] na);
        bus(1'b1, pmc_pkg::OFF_RET_ADDR, na);
        bus(1'b1, pmc_pkg::OFF_EVENT,
            {25'h0, pmc_pkg::OP_RET, pmc_pkg::EV_MODEOP});
        @(posedge sys_clk);
        #1;
        cmp(fetch_pc, na);
        cmp(flg(), 32'hE);
    endtask : to_native

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // read data stand only the cycle after the strobe; timeout guard too
    always @(posedge sys_clk) begin
        rd_d <= rd;
        cycles <= cycles + 1;
        if (rd_d)
            cmp(rdata, exp_q.pop_front());
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        #1;
        cmp(flg(), 32'h14);
        cmp(fetch_pc, 32'h0);
        rdx(pmc_pkg::OFF_BASE, pmc_pkg::RST_BASE);
        rdx(8'hFC, 32'h0);
        rdx(pmc_pkg::OFF_STATUS, 32'h1);
        rnd = lfsr(32'h179D);
        base = rnd & 32'h00FF_C000;
        bus(1'b1, pmc_pkg::OFF_BASE, base);
        rdx(pmc_pkg::OFF_BASE, base);
        bus(1'b1, pmc_pkg::OFF_CTRL, 32'h1);
        bus(1'b1, pmc_pkg::OFF_IRQ_EN, 32'h1);
        #1;
        cmp(flg(), 32'h15);
        // top scratch index written and read back
        evw = {rnd[15:0], 8'h17, 1'b0, pmc_pkg::OP_MTIR, pmc_pkg::EV_MODEOP};
        bus(1'b1, pmc_pkg::OFF_EVENT, evw);
        evw = {24'h17, 1'b0, pmc_pkg::OP_MFIR, pmc_pkg::EV_MODEOP};
        bus(1'b1, pmc_pkg::OFF_EVENT, evw);
        rdx(pmc_pkg::OFF_SCRATCH, {16'h0, rnd[15:0]});
        // each of the six entry event codes, then every mode-only op from native mode
        for (int i = 0; i < 11; i++) begin
            rnd = lfsr(rnd);
            x = rnd & 32'h0FFF_FFFC;
            to_native(x);
            // wipe the saved address so only the entry save can restore x
            bus(1'b1, pmc_pkg::OFF_RET_ADDR, 32'h0);
            evw = i < 6 ? {28'h0, EVS[i]} :
                  {25'h0, 3'(i - 6), pmc_pkg::EV_MODEOP};
            bus(1'b1, pmc_pkg::OFF_EVENT, evw);
            repeat (6) @(posedge sys_clk);
            #1;
            evw = base + (i < 6 ? OFFS[i] : pmc_pkg::ENT_ILLOP);
            cmp(fetch_pc, evw);
            cmp({31'h0, fw_mode}, 32'h1);
            rdx(pmc_pkg::OFF_RET_ADDR, x);
            rdx(pmc_pkg::OFF_PC, evw | 32'h1);
            rdx(pmc_pkg::OFF_IRQ_STAT, i < 6 ? 32'h3 : 32'h7);
            #1;
            cmp(flg(), 32'h15);
            cmp({31'h0, irq}, 32'h1);
            bus(1'b1, pmc_pkg::OFF_IRQ_CLR, 32'h7);
            @(posedge sys_clk);
            #1;
            cmp({31'h0, irq}, 32'h0);
        end
        // interrupt entry with the output masked; request held in firmware
        bus(1'b1, pmc_pkg::OFF_IRQ_EN, 32'h0);
        to_native(x);
        @(posedge sys_clk);
        intr_req <= 1'b1;
        for (int k = 0; k < 30 && fw_mode !== 1'b1; k++)
            @(posedge sys_clk);
        repeat (10) @(posedge sys_clk);
        #1;
        cmp(fetch_pc, base + pmc_pkg::ENT_INTR);
        cmp(flg(), 32'h15);
        cmp({31'h0, irq}, 32'h0);
        @(posedge sys_clk);
        intr_req <= 1'b0;
        bus(1'b1, pmc_pkg::OFF_IRQ_EN, 32'h1);
        @(posedge sys_clk);
        #1;
        cmp({31'h0, irq}, 32'h1);
        bus(1'b1, pmc_pkg::OFF_IRQ_CLR, 32'h7);
        @(posedge sys_clk);
        #1;
        cmp({31'h0, irq}, 32'h0);
        // return with bit 0 set stays in firmware mode
        bus(1'b1, pmc_pkg::OFF_RET_ADDR, x | 32'h1);
        bus(1'b1, pmc_pkg::OFF_EVENT,
            {25'h0, pmc_pkg::OP_RET, pmc_pkg::EV_MODEOP});
        @(posedge sys_clk);
        #1;
        cmp(flg(), 32'h15);
        cmp(fetch_pc, x);
        end_of_test();
    end
endmodule : pmc_top_tb

bind pmc_top pmc_checker u_chk (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .FETCH_PC(FETCH_PC), .FW_MODE(FW_MODE), .IMAP_EN(IMAP_EN),
    .DMAP_EN(DMAP_EN), .INTR_EN(INTR_EN), .SHADOW_SEL(SHADOW_SEL),
    .IRQ(IRQ)
);
`default_nettype wire
